// ### logic/lps_pkg.sv
// constants for the low-power sequencer and its status registers
// assumes a 32-bit apb slave with word-aligned registers
package lps_pkg;
	// ==========================================
	// register map (byte addresses)
	localparam logic [15:0] ADDR_IRQ_LOW = 16'hfe04;
	localparam logic [15:0] ADDR_RESET_CAUSE = 16'hfe00;
	localparam logic [15:0] ADDR_IRQ_MID = 16'hfe08;
	localparam logic [15:0] ADDR_IRQ_HIGH = 16'hfe0c;
	localparam logic [15:0] ADDR_CONFIG = 16'hfe10;
	localparam logic [15:0] ADDR_STATE = 16'hfe14;
	// ==========================================
	// reset cause bit positions
	localparam int RC_POR = 7;
	localparam int RC_WDOG = 6;
	localparam int RC_BAD_OP = 5;
	localparam int RC_BAD_FETCH = 4;
	localparam int RC_MONITOR = 3;
	localparam int RC_LOW_V = 1;
	localparam logic [7:0] RC_POR_VALUE = 8'h80;
	// ==========================================
	// config bits
	localparam int CFG_SHORT_REC = 0;
	localparam int CFG_OSC_STOP = 1;
	localparam int CFG_WDOG_DIS = 2;
	localparam int CFG_STOP_EN = 3;
	localparam logic [7:0] CFG_RESET = 8'h00;
	// ==========================================
	// recovery timing in oscillator cycles
	localparam int REC_LONG = 4096;
	localparam int REC_SHORT = 32;
	localparam int NUM_IRQ = 11;
	typedef enum logic [1:0] {
		LPS_RUN = 2'b00,
		LPS_WAIT = 2'b01,
		LPS_STOP = 2'b11,
		LPS_RECOVER = 2'b10
	} lps_state_t;
endpackage

// ### logic/lps_ctrl.sv
// low-power sequencer, reset cause and pending interrupt status registers
// assumes mclk is the oscillator clock; inputs are synchronous to it
//
// Summary of operation
// - wait or stop stops cpu clock
// - wait or stop clears interrupt mask
// - leave low power only on interrupt or reset
// - wait keeps peripheral clocks running
// - wait wake needs enabled interrupt
// - wait wake stacking one cycle later
// - watchdog runs in wait unless disabled
// - stop clears counter, gates cpu and peripheral clocks
// - stop disables clockgen outputs unless allowed
// - clocks restart after full recovery delay
// - interrupt exit: 32 or 4096 cycles
// - stop stacking after recovery delay
// - reset exit uses 4096 cycles; power-on with a short-recovery wake pending uses 32
// - counter cleared in stop, then counts
// - reading reset cause clears it
// - power-on sets only power-on bit
// - cause bits show last reset source
// - mask blocks all except software interrupt
// - status flags mirror pending requests
// - low register flags 5..1 at 6..2
// - unused flags zero, 11 and 10 live
// - stop disabled means illegal opcode reset
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`default_nettype none
module lps_ctrl #(
	parameter int LONG_CYCLES = lps_pkg::REC_LONG,
	parameter int SHORT_CYCLES = lps_pkg::REC_SHORT
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic wait_exec,
	input wire logic stop_exec,
	input wire logic swi_exec,
	input wire logic [lps_pkg::NUM_IRQ-1:0] irq_req,
	input wire logic [lps_pkg::NUM_IRQ-1:0] irq_en,
	input wire logic mask_set,
	input wire logic por_event,
	input wire logic wdog_event,
	input wire logic bad_fetch_event,
	input wire logic monitor_event,
	input wire logic low_v_event,
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output logic clockgen_bus_output_en,
	output logic osc_clock_en,
	output logic wdog_run,
	output logic irq_mask,
	output logic stack_start,
	output logic bad_opcode_reset,
	output logic sys_reset_req
);
	import lps_pkg::*;

	lps_state_t state;
	logic [12:0] rec_count;
	logic [12:0] rec_target;
	logic [7:0] reset_cause;
	logic [7:0] cfg;
	logic wake_irq;
	logic maskable_pend;
	logic any_reset;
	logic rd_cause;
	logic wr_cfg;
	logic rec_done;
	logic rec_from_irq;

	// ==========================================
	// apb slave
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign rd_cause = psel && penable && !pwrite &&
		paddr == ADDR_RESET_CAUSE;
	assign wr_cfg = psel && penable && pwrite && paddr == ADDR_CONFIG;

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			cfg <= CFG_RESET;
		end else if (wr_cfg) begin
			cfg <= pwdata[7:0];
		end
	end

	function automatic logic [7:0] irq_word(input logic [15:0] a,
		input logic [NUM_IRQ-1:0] r);
		logic [7:0] w;
		w = 8'h00;
		if (a == ADDR_IRQ_LOW) begin
			w = {1'b0, r[4:0], 2'b00};
		end else if (a == ADDR_IRQ_MID) begin
			w = {r[8:5], 4'h0};
		end else if (a == ADDR_IRQ_HIGH) begin
			w = {6'h00, r[10:9]};
		end
		return w;
	endfunction

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			prdata <= 32'h0;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				ADDR_RESET_CAUSE: prdata <= {24'h0, reset_cause};
				ADDR_CONFIG: prdata <= {24'h0, cfg};
				ADDR_STATE: prdata <= {30'h0, state};
				default: prdata <= {24'h0, irq_word(paddr, irq_req)};
			endcase
		end
	end

	// ==========================================
	// reset cause register
	assign bad_opcode_reset = stop_exec && !cfg[CFG_STOP_EN];
	assign any_reset = wdog_event || bad_opcode_reset || bad_fetch_event
		|| monitor_event || low_v_event;
	assign sys_reset_req = any_reset;

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			reset_cause <= RC_POR_VALUE;
		end else if (por_event) begin
			reset_cause <= RC_POR_VALUE;
		end else if (any_reset) begin
			reset_cause <= 8'h00;
			reset_cause[RC_WDOG] <= wdog_event;
			reset_cause[RC_BAD_OP] <= bad_opcode_reset;
			reset_cause[RC_BAD_FETCH] <= bad_fetch_event;
			reset_cause[RC_MONITOR] <= monitor_event;
			reset_cause[RC_LOW_V] <= low_v_event;
		end else if (rd_cause) begin
			reset_cause <= 8'h00;
		end
	end

	// ==========================================
	// low-power sequencer
	// only enabled sources wake
	assign maskable_pend = |(irq_req & irq_en);
	assign wake_irq = maskable_pend && !irq_mask;

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			irq_mask <= 1'b1;
		end else if (wait_exec || (stop_exec && cfg[CFG_STOP_EN])) begin
			irq_mask <= 1'b0;
		end else if (mask_set || stack_start) begin
			irq_mask <= 1'b1;
		end
	end

	// exits by interrupt or reset only
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			state <= LPS_RUN;
			rec_from_irq <= 1'b0;
		end else begin
			unique case (state)
				LPS_RUN: begin
					if (wait_exec) begin
						state <= LPS_WAIT;
					end else if (stop_exec && cfg[CFG_STOP_EN]) begin
						state <= LPS_STOP;
					end
				end
				LPS_WAIT: begin
					if (wake_irq || any_reset) begin
						state <= LPS_RUN;
					end
				end
				LPS_STOP: begin
					if (any_reset || por_event) begin
						state <= LPS_RECOVER;
						rec_from_irq <= 1'b0;
					end else if (wake_irq) begin
						state <= LPS_RECOVER;
						rec_from_irq <= 1'b1;
					end
				end
				LPS_RECOVER: begin
					if (rec_done) begin
						state <= LPS_RUN;
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			rec_target <= 13'(LONG_CYCLES - 1);
		end else if (state == LPS_STOP) begin
			if (wake_irq && !any_reset && cfg[CFG_SHORT_REC]) begin
				rec_target <= 13'(SHORT_CYCLES - 1);
			end else begin
				rec_target <= 13'(LONG_CYCLES - 1);
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			rec_count <= 13'h0;
		end else if (state == LPS_RECOVER) begin
			rec_count <= rec_count + 13'h1;
		end else begin
			rec_count <= 13'h0;
		end
	end
	assign rec_done = state == LPS_RECOVER && rec_count == rec_target;

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			stack_start <= 1'b0;
		end else begin
			stack_start <= (state == LPS_WAIT && wake_irq && !any_reset) ||
				(rec_done && rec_from_irq) || swi_exec;
		end
	end

	assign cpu_clk_en = state == LPS_RUN;
	assign periph_clk_en = state == LPS_RUN || state == LPS_WAIT;
	// clockgen off in stop unless allowed
	assign clockgen_bus_output_en = !(state == LPS_STOP &&
		!cfg[CFG_OSC_STOP]);
	assign osc_clock_en = clockgen_bus_output_en;
	assign wdog_run = !cfg[CFG_WDOG_DIS] && state != LPS_STOP;

	// ==========================================
	// checks
	sequence s_stop_wake;
		state == LPS_STOP && wake_irq && !any_reset && !por_event;
	endsequence

	a_wait_stack: assert property (@(posedge mclk) disable iff (!rst_b)
		state == LPS_WAIT && wake_irq && !any_reset |=> stack_start)
		else $error("no stacking after wait wake");
	a_stop_gates: assert property (@(posedge mclk) disable iff (!rst_b)
		state == LPS_STOP |-> !cpu_clk_en && !periph_clk_en)
		else $error("clocks run in stop");
	a_short_rec: assert property (@(posedge mclk) disable iff (!rst_b)
		s_stop_wake and cfg[CFG_SHORT_REC] |=>
		(!cpu_clk_en)[*8] ##[1:40] cpu_clk_en)
		else $error("short recovery wrong");
	a_reset_long: assert property (@(posedge mclk) disable iff (!rst_b)
		state == LPS_STOP && any_reset |=> rec_target ==
		13'(LONG_CYCLES - 1))
		else $error("reset exit not long");
	a_cause_clear: assert property (@(posedge mclk) disable iff (!rst_b)
		rd_cause && !any_reset && !por_event |=> reset_cause == 8'h00)
		else $error("cause not cleared by read");
	a_por_value: assert property (@(posedge mclk) disable iff (!rst_b)
		por_event |=> reset_cause == RC_POR_VALUE)
		else $error("power-on value wrong");
	a_mask_clear: assert property (@(posedge mclk) disable iff (!rst_b)
		wait_exec |=> !irq_mask)
		else $error("mask not cleared");
	a_osc_off: assert property (@(posedge mclk) disable iff (!rst_b)
		state == LPS_STOP && !cfg[CFG_OSC_STOP] |-> !osc_clock_en)
		else $error("oscillator on in stop");
	a_stop_illegal: assert property (@(posedge mclk) disable iff (!rst_b)
		stop_exec && !cfg[CFG_STOP_EN] && state == LPS_RUN && !wait_exec
		|=> state == LPS_RUN)
		else $error("disabled stop entered");
	a_wdog_wait: assert property (@(posedge mclk) disable iff (!rst_b)
		state == LPS_WAIT && !cfg[CFG_WDOG_DIS] |-> wdog_run)
		else $error("watchdog stopped in wait");

	// ==========================================
	// sequencer step checks
	sequence s_wait_idle;
		state == LPS_WAIT && !wake_irq && !any_reset;
	endsequence

	sequence s_stop_idle;
		state == LPS_STOP && !wake_irq && !any_reset && !por_event;
	endsequence

	sequence s_rec_step;
		state == LPS_RECOVER && !rec_done;
	endsequence

	a_cpu_off: assert property (@(posedge mclk) disable iff (!rst_b)
		state != LPS_RUN |-> !cpu_clk_en)
		else $error("cpu clock runs in low power");
	a_stop_mask: assert property (@(posedge mclk) disable iff (!rst_b)
		stop_exec && cfg[CFG_STOP_EN] |=> !irq_mask)
		else $error("mask not cleared by stop");
	a_wait_hold: assert property (@(posedge mclk) disable iff (!rst_b)
		s_wait_idle |=> state == LPS_WAIT)
		else $error("wait left without cause");
	a_stop_hold: assert property (@(posedge mclk) disable iff (!rst_b)
		s_stop_idle |=> state == LPS_STOP)
		else $error("stop left without cause");
	a_wait_clocks: assert property (@(posedge mclk) disable iff (!rst_b)
		state == LPS_WAIT |-> !cpu_clk_en && periph_clk_en)
		else $error("wait clock gating wrong");
	a_disabled_src: assert property (@(posedge mclk) disable iff (!rst_b)
		state == LPS_WAIT && !(|(irq_req & irq_en)) && !any_reset
		|=> state == LPS_WAIT)
		else $error("disabled source woke core");
	a_rec_gates: assert property (@(posedge mclk) disable iff (!rst_b)
		state == LPS_RECOVER |-> !cpu_clk_en && !periph_clk_en)
		else $error("clocks run during recovery");
	a_stop_counter: assert property (@(posedge mclk) disable iff (!rst_b)
		state == LPS_STOP |-> rec_count == 13'h0)
		else $error("counter not held in stop");
	a_rec_counts: assert property (@(posedge mclk) disable iff (!rst_b)
		s_rec_step |=> rec_count == $past(rec_count) + 13'h1)
		else $error("recovery counter stalled");
	a_stop_stack: assert property (@(posedge mclk) disable iff (!rst_b)
		rec_done && rec_from_irq |=> stack_start)
		else $error("no stacking after recovery");
	a_swi_stack: assert property (@(posedge mclk) disable iff (!rst_b)
		swi_exec |=> stack_start)
		else $error("software interrupt not taken");
	a_mask_block: assert property (@(posedge mclk) disable iff (!rst_b)
		irq_mask && !swi_exec && state == LPS_RUN |=> !stack_start)
		else $error("masked interrupt taken");
	a_low_layout: assert property (@(posedge mclk) disable iff (!rst_b)
		psel && !penable && !pwrite && paddr == ADDR_IRQ_LOW |=>
		prdata[1:0] == 2'h0 && prdata[31:7] == 25'h0)
		else $error("low flag register layout wrong");
	a_mid_unused: assert property (@(posedge mclk) disable iff (!rst_b)
		psel && !penable && !pwrite && paddr == ADDR_IRQ_MID |=>
		prdata[3:0] == 4'h0 && prdata[31:8] == 24'h0)
		else $error("unused mid flags set");
	a_cause_nowrite: assert property (@(posedge mclk) disable iff (!rst_b)
		psel && penable && pwrite && !any_reset && !por_event
		|=> reset_cause == $past(reset_cause))
		else $error("write changed reset cause");
endmodule
`default_nettype wire

// ### dv/lps_cpu_model.sv
// stand-in for the cpu core and the peripheral interrupt sources
// assumes the bench calls its tasks just after a rising edge of mclk
`timescale 1ns/1ps
`default_nettype none
module lps_cpu_model
	import lps_pkg::*;
(
	input wire logic mclk,
	input wire logic stack_start,
	output logic wait_exec,
	output logic stop_exec,
	output logic swi_exec,
	output logic mask_set,
	output logic [lps_pkg::NUM_IRQ-1:0] irq_req,
	output logic [lps_pkg::NUM_IRQ-1:0] irq_en
);
	initial begin
		wait_exec = 1'b0;
		stop_exec = 1'b0;
		swi_exec = 1'b0;
		mask_set = 1'b0;
		irq_req = '0;
		irq_en = '0;
	end
	// interrupt entry sets the mask again, as a real core does
	always @(posedge mclk) begin
		mask_set <= stack_start;
	end
	// one-cycle instruction pulse
	task automatic exec(input logic w, input logic s);
		wait_exec <= w;
		stop_exec <= s;
		@(posedge mclk);
		wait_exec <= 1'b0;
		stop_exec <= 1'b0;
	endtask
	task automatic sources(input logic [NUM_IRQ-1:0] r,
		input logic [NUM_IRQ-1:0] e);
		irq_req <= r;
		irq_en <= e;
	endtask
endmodule
`default_nettype wire

// ### dv/low_power_and_status_ctrl_tb.sv
// self-checking bench for the low-power sequencer and status registers
// assumes the recovery count is shortened to 64 through LONG_CYCLES
`timescale 1ns/1ps
`default_nettype none
module low_power_and_status_ctrl_tb;
	import lps_pkg::*;
	localparam int LONG = 64;
	logic mclk, rst_b, psel, penable, pwrite, pready, pslverr;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic wait_exec, stop_exec, swi_exec, mask_set, stack_start;
	logic [NUM_IRQ-1:0] irq_req, irq_en;
	logic por_event, wdog_event, bad_fetch_event, monitor_event, low_v_event;
	logic cpu_clk_en, periph_clk_en, cg_en, osc_en, wdog_run, irq_mask;
	logic bad_opcode_reset, sys_reset_req;
	int fails = 0;
	int comparisons = 0;
	lps_ctrl #(.LONG_CYCLES(LONG)) lps_ctrl_i (.mclk(mclk), .rst_b(rst_b),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .wait_exec(wait_exec), .stop_exec(stop_exec),
		.swi_exec(swi_exec), .irq_req(irq_req), .irq_en(irq_en),
		.mask_set(mask_set), .por_event(por_event),
		.wdog_event(wdog_event), .bad_fetch_event(bad_fetch_event),
		.monitor_event(monitor_event), .low_v_event(low_v_event),
		.cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
		.clockgen_bus_output_en(cg_en), .osc_clock_en(osc_en),
		.wdog_run(wdog_run), .irq_mask(irq_mask),
		.stack_start(stack_start), .bad_opcode_reset(bad_opcode_reset),
		.sys_reset_req(sys_reset_req));
	lps_cpu_model lps_cpu_model_i (.mclk(mclk), .stack_start(stack_start),
		.wait_exec(wait_exec), .stop_exec(stop_exec), .swi_exec(swi_exec),
		.mask_set(mask_set), .irq_req(irq_req), .irq_en(irq_en));
	// ==========================================
	// common tasks
	task automatic chk(input string n, input logic [31:0] s,
		input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	// apb transfer; holds the request until pready is seen at an edge
	task automatic apb(input logic w, input logic [15:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		// one idle edge so a following call never re-drives psel at once
		@(posedge mclk);
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk("read data", q, e);
	endtask
	task automatic report_and_stop();
		if (fails == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// ==========================================
	// scenarios
	task automatic status_regs();
		rd(ADDR_RESET_CAUSE, 32'h80);
		rd(ADDR_RESET_CAUSE, 32'h0);
		lps_cpu_model_i.sources(11'h7ff, 11'h0);
		apb(1'b1, ADDR_IRQ_LOW, 32'hff);
		apb(1'b1, ADDR_RESET_CAUSE, 32'hff);
		rd(ADDR_IRQ_LOW, 32'h7c);
		rd(ADDR_IRQ_MID, 32'hf0);
		rd(ADDR_IRQ_HIGH, 32'h03);
		rd(ADDR_RESET_CAUSE, 32'h0);
		lps_cpu_model_i.sources(11'h0, 11'h0);
		rd(ADDR_IRQ_LOW, 32'h0);
	endtask
	task automatic cause_bits();
		logic [7:0] exp [4] = '{8'h40, 8'h10, 8'h08, 8'h02};
		for (int i = 0; i < 4; i++) begin
			{wdog_event, bad_fetch_event, monitor_event, low_v_event} <=
				4'h8 >> i;
			@(posedge mclk);
			{wdog_event, bad_fetch_event, monitor_event, low_v_event} <= 4'h0;
			rd(ADDR_RESET_CAUSE, {24'h0, exp[i]});
		end
		por_event <= 1'b1;
		@(posedge mclk);
		por_event <= 1'b0;
		rd(ADDR_RESET_CAUSE, 32'h80);
	endtask
	task automatic wait_wake();
		int n;
		n = 0;
		lps_cpu_model_i.exec(1'b1, 1'b0);
		#1;
		chk("cpu clock in wait", cpu_clk_en, 1'b0);
		chk("periph clock in wait", periph_clk_en, 1'b1);
		chk("mask after wait", irq_mask, 1'b0);
		chk("watchdog in wait", wdog_run, 1'b1);
		@(posedge mclk);
		// a pending but disabled request must not wake the core
		lps_cpu_model_i.sources(11'h001, 11'h0);
		repeat (4) @(posedge mclk);
		chk("disabled wake", cpu_clk_en, 1'b0);
		lps_cpu_model_i.sources(11'h001, 11'h001);
		do begin
			@(posedge mclk);
			#1;
			n++;
		end while (stack_start !== 1'b1 && n < 10);
		chk("wait stacking delay", n == 1, 1'b1);
		@(posedge mclk);
		lps_cpu_model_i.sources(11'h0, 11'h0);
		repeat (3) @(posedge mclk);
	endtask
	task automatic stop_run(input logic [7:0] cfg, input int lo);
		int n;
		n = 0;
		apb(1'b1, ADDR_CONFIG, {24'h0, cfg});
		lps_cpu_model_i.exec(1'b0, 1'b1);
		#1;
		chk("cpu clock in stop", cpu_clk_en, 1'b0);
		chk("periph clock in stop", periph_clk_en, 1'b0);
		chk("osc in stop", osc_en, cfg[1]);
		chk("bus clock in stop", cg_en, cfg[1]);
		@(posedge mclk);
		lps_cpu_model_i.sources(11'h400, 11'h400);
		do begin
			@(posedge mclk);
			#1;
			n++;
		end while (cpu_clk_en !== 1'b1 && n < 5000);
		chk("recovery length", n >= lo && n <= lo + 3, 1'b1);
		chk("stack after recovery", stack_start, 1'b1);
		@(posedge mclk);
		lps_cpu_model_i.sources(11'h0, 11'h0);
		repeat (4) @(posedge mclk);
	endtask
	task automatic stop_reset();
		int n;
		n = 1;
		apb(1'b1, ADDR_CONFIG, 32'h09);
		lps_cpu_model_i.exec(1'b0, 1'b1);
		wdog_event <= 1'b1;
		@(posedge mclk);
		wdog_event <= 1'b0;
		do begin
			@(posedge mclk);
			#1;
			n++;
		end while (cpu_clk_en !== 1'b1 && n < 5000);
		chk("reset exit length", n >= LONG && n <= LONG + 3, 1'b1);
		chk("stack after reset exit", stack_start, 1'b0);
		@(posedge mclk);
	endtask
	task automatic stop_refused();
		apb(1'b1, ADDR_CONFIG, 32'h0);
		fork
			lps_cpu_model_i.exec(1'b0, 1'b1);
			begin
				#1;
				chk("stop as bad opcode", bad_opcode_reset, 1'b1);
			end
		join
		rd(ADDR_RESET_CAUSE, 32'h20);
	endtask
	// ==========================================
	// clock, reset, sequence and watchdog
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	initial begin
		#200000;
		fails++;
		report_and_stop();
	end
	initial begin
		{rst_b, psel, penable, pwrite} = 4'h0;
		paddr = 16'h0;
		pwdata = 32'h0;
		{por_event, wdog_event, bad_fetch_event} = 3'h0;
		{monitor_event, low_v_event} = 2'h0;
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		status_regs();
		cause_bits();
		wait_wake();
		stop_run(8'h09, REC_SHORT);
		// crystal-style setup keeps short recovery clear
		stop_run(8'h08, LONG);
		stop_run(8'h0a, LONG);
		stop_reset();
		stop_refused();
		report_and_stop();
	end
endmodule
`default_nettype wire
